// file: rtl/socket_power_pkg.sv
// Constants for the socket voltage request and clock idle control registers
package socket_power_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_VOLTAGE_REQUEST = 8'h10;
   localparam logic [7:0] OFS_CLOCK_IDLE_CONTROL = 8'h20;
   // Voltage request register fields
   localparam int VREQ_ONE_BIT = 10;
   localparam int VREQ_POLICY_BIT = 7;
   localparam int VREQ_CARD_HI = 6;
   localparam int VREQ_CARD_LO = 4;
   localparam int VREQ_PROG_HI = 2;
   localparam int VREQ_PROG_LO = 0;
   // Clock idle control register fields
   localparam int IDLE_ACCESSED_BIT = 25;
   localparam int IDLE_MODE_BIT = 24;
   localparam int IDLE_ENABLE_BIT = 16;
   localparam int IDLE_SELECT_BIT = 0;
   // Card supply request codes
   localparam logic [2:0] VCC_OFF = 3'h0;
   localparam logic [2:0] VCC_5V = 3'h2;
   localparam logic [2:0] VCC_3V3 = 3'h3;
   localparam logic [2:0] VCC_ALT_Y = 3'h5;
   // Programming supply request codes
   localparam logic [2:0] VPP_OFF = 3'h0;
   localparam logic [2:0] VPP_12V = 3'h1;
   localparam logic [2:0] VPP_5V = 3'h2;
   localparam logic [2:0] VPP_3V3 = 3'h3;
   localparam logic [2:0] VPP_ALT_X = 3'h4;
   localparam logic [2:0] VPP_ALT_Y = 3'h5;
   // Reset values
   localparam logic [2:0] SUPPLY_RESET = 3'h0;
   localparam logic POLICY_RESET = 1'b0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Card clock states
   typedef enum logic [1:0] {CLK_RUN, CLK_STOP, CLK_SLOW} card_clock_e;
endpackage : socket_power_pkg

// file: rtl/socket_power_regs.sv
// Socket voltage request and card clock idle control register bank
// Notes on behaviour
// - Voltage request bits 31-11, 9-8 and 3 read zero, bit 10 reads one, writes there do nothing.
// - Policy bit 7 picks whether an idle socket alone, or idle plus host clock-run, stops the card clock.
// - Card supply field 6-4: 000 off, 010 5 V, 011 3.3 V, 101 alternate; 001, 110, 111 reserved.
// - Program supply field 2-0: 000 off, 001 12 V, 010 5 V, 011 3.3 V, 100/101 alternate; 110, 111 reserved.
// - With a CardBus card inserted, power goes on only at a voltage the card accepts.
// - Supply fields survive the host bus reset while power events are enabled, else either reset clears them.
// - Clock idle control resets to zero, only bits 16 and 0 are writable, bits 25 and 24 read status, others read zero.
// - The block slows or stops the card clock while the card is idle, governed by that register.
// - Bit 16 enables clock control; bit 0 at 0 stops the clock, at 1 slows it by 16.
// - Socket accessed flag sets on any card access, clears on a read, else only by general reset.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Block overview
// Two registers on a plain strobe port
// Voltage request word holds policy and both supply codes
// Clock idle word holds throttle enable and select
// Accessed flag and clock mode are status only
// Unmapped addresses read zero and ignore writes
// Read data registered, valid one cycle after the strobe
// Read data returns to zero when no read was taken
// Slave never stalls, so back to back strobes are fine
//
// Power switch side
// Card supply follows the request only when accepted
// Reserved card codes keep the socket unpowered
// Program supply goes on only with an accepted card supply, on the same edge
// Reserved program codes read back but drive nothing
// Switch codes come from flip-flops, no decode glitches
// Supply follows request and sense lines a cycle later
// Removing the card drops both supplies at once
//
// Reset handling
// General reset is asynchronous and clears everything
// Host bus reset is sampled on the clock edge
// It clears only the supply fields, and only with events off
// With events on, supply requests survive host bus resets
// Host bus reset beats a write in the same cycle
// Accessed flag is touched by the general reset only
//
// Card clock control
// Enable gates everything; with it low the clock runs
// Select low stops the clock, high slows it by sixteen
// Policy high acts on an idle socket alone
// Policy low also waits for the host clock-run request
// Any card access in a cycle keeps the clock running
// Stop and slow outputs are never both high, decoded from one state register (both low while running)
// Clock mode status reads one while stopped or slowed
//
// Limitations
// Sense inputs are taken as synchronous to the clock
// An outside socket block must resynchronise raw pins
// Accessed flag set wins over a clear by the same read
// So a read may show zero and the flag set again next
// No interrupt or event logic lives in this block
//
module socket_power_regs (
   // Clock and resets
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic HOST_BUS_RESET,
   input wire logic PM_EVENT_ENABLE,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Card status from socket logic
   input wire logic CARD_INSERTED,
   input wire logic CARD_ACCEPTS_5V,
   input wire logic CARD_ACCEPTS_3V3,
   input wire logic CARD_ACCEPTS_ALT,
   input wire logic CARD_IDLE,
   input wire logic CARD_ACCESS,
   input wire logic HOST_CLKRUN_STOPPING,
   // Power switch and card clock control
   output logic [2:0] CARD_SUPPLY,
   output logic [2:0] PROGRAM_SUPPLY,
   output logic CARD_CLOCK_STOP,
   output logic CARD_CLOCK_SLOW
);
   logic [2:0] card_supply_request_r, card_supply_request_nxt;
   logic [2:0] program_supply_request_r, program_supply_request_nxt;
   logic clock_halt_policy_r, clock_halt_policy_nxt;
   logic clock_throttle_enable_r, clock_throttle_enable_nxt;
   logic clock_throttle_select_r, clock_throttle_select_nxt;
   logic socket_accessed_flag_r, socket_accessed_flag_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [2:0] card_supply_r, card_supply_nxt;
   logic [2:0] program_supply_r, program_supply_nxt;
   socket_power_pkg::card_clock_e clk_state_r, clk_state_nxt;
   logic supply_clear;
   logic vcc_ok;
   logic idle_ok;

   // Host bus reset clears supply fields only while power events are off
   assign supply_clear = HOST_BUS_RESET && !PM_EVENT_ENABLE;

   // Card supply codes the inserted card can take; reserved codes never pass
   function automatic logic vcc_acceptable(input logic [2:0] code, input logic a5,
                                           input logic a3, input logic ay);
      unique case (code)
         socket_power_pkg::VCC_5V: vcc_acceptable = a5;
         socket_power_pkg::VCC_3V3: vcc_acceptable = a3;
         socket_power_pkg::VCC_ALT_Y: vcc_acceptable = ay;
         default: vcc_acceptable = 1'b0;
      endcase
   endfunction : vcc_acceptable

   // Register address match, shared by write and read decode
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction : addr_hit

   // Program supply codes that are defined; reserved ones drive off
   function automatic logic vpp_defined(input logic [2:0] code);
      vpp_defined = (code <= socket_power_pkg::VPP_ALT_Y);
   endfunction : vpp_defined

   assign vcc_ok = CARD_INSERTED &&
      vcc_acceptable(card_supply_request_r, CARD_ACCEPTS_5V, CARD_ACCEPTS_3V3, CARD_ACCEPTS_ALT);
   // Policy 0 waits for host clock-run, policy 1 acts on idle alone
   assign idle_ok = CARD_IDLE && (clock_halt_policy_r || HOST_CLKRUN_STOPPING);

   // Register writes, read data and access flag
   always_comb begin
      card_supply_request_nxt = card_supply_request_r;
      program_supply_request_nxt = program_supply_request_r;
      clock_halt_policy_nxt = clock_halt_policy_r;
      clock_throttle_enable_nxt = clock_throttle_enable_r;
      clock_throttle_select_nxt = clock_throttle_select_r;
      socket_accessed_flag_nxt = socket_accessed_flag_r;
      rdata_nxt = socket_power_pkg::ZERO_WORD;
      if (WR && addr_hit(ADDR, socket_power_pkg::OFS_VOLTAGE_REQUEST)) begin
         // Only policy and supply fields store; others are constants
         clock_halt_policy_nxt = WDATA[socket_power_pkg::VREQ_POLICY_BIT];
         card_supply_request_nxt =
            WDATA[socket_power_pkg::VREQ_CARD_HI:socket_power_pkg::VREQ_CARD_LO];
         program_supply_request_nxt =
            WDATA[socket_power_pkg::VREQ_PROG_HI:socket_power_pkg::VREQ_PROG_LO];
      end
      if (WR && addr_hit(ADDR, socket_power_pkg::OFS_CLOCK_IDLE_CONTROL)) begin
         clock_throttle_enable_nxt = WDATA[socket_power_pkg::IDLE_ENABLE_BIT];
         clock_throttle_select_nxt = WDATA[socket_power_pkg::IDLE_SELECT_BIT];
      end
      if (RD && addr_hit(ADDR, socket_power_pkg::OFS_VOLTAGE_REQUEST)) begin
         rdata_nxt[socket_power_pkg::VREQ_ONE_BIT] = 1'b1;
         rdata_nxt[socket_power_pkg::VREQ_POLICY_BIT] = clock_halt_policy_r;
         rdata_nxt[socket_power_pkg::VREQ_CARD_HI:socket_power_pkg::VREQ_CARD_LO] =
            card_supply_request_r;
         rdata_nxt[socket_power_pkg::VREQ_PROG_HI:socket_power_pkg::VREQ_PROG_LO] =
            program_supply_request_r;
      end
      if (RD && addr_hit(ADDR, socket_power_pkg::OFS_CLOCK_IDLE_CONTROL)) begin
         rdata_nxt[socket_power_pkg::IDLE_ACCESSED_BIT] = socket_accessed_flag_r;
         rdata_nxt[socket_power_pkg::IDLE_MODE_BIT] = (clk_state_r != socket_power_pkg::CLK_RUN);
         rdata_nxt[socket_power_pkg::IDLE_ENABLE_BIT] = clock_throttle_enable_r;
         rdata_nxt[socket_power_pkg::IDLE_SELECT_BIT] = clock_throttle_select_r;
         socket_accessed_flag_nxt = 1'b0;
      end
      // A new access in the read cycle wins over the clear
      if (CARD_ACCESS) begin
         socket_accessed_flag_nxt = 1'b1;
      end
      if (supply_clear) begin
         card_supply_request_nxt = socket_power_pkg::SUPPLY_RESET;
         program_supply_request_nxt = socket_power_pkg::SUPPLY_RESET;
      end
   end

   // Power switch drive and card clock state
   always_comb begin
      card_supply_nxt = socket_power_pkg::VCC_OFF;
      program_supply_nxt = socket_power_pkg::VPP_OFF;
      // Unacceptable Vcc keeps the socket fully unpowered
      if (vcc_ok) begin
         card_supply_nxt = card_supply_request_r;
         if (vpp_defined(program_supply_request_r)) begin
            program_supply_nxt = program_supply_request_r;
         end
      end
      clk_state_nxt = socket_power_pkg::CLK_RUN;
      if (clock_throttle_enable_r && idle_ok && !CARD_ACCESS) begin
         clk_state_nxt = clock_throttle_select_r ? socket_power_pkg::CLK_SLOW
                                                 : socket_power_pkg::CLK_STOP;
      end
   end

   // General reset clears all; supply fields also follow supply_clear above
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         card_supply_request_r <= socket_power_pkg::SUPPLY_RESET;
         program_supply_request_r <= socket_power_pkg::SUPPLY_RESET;
         clock_halt_policy_r <= socket_power_pkg::POLICY_RESET;
         clock_throttle_enable_r <= 1'b0;
         clock_throttle_select_r <= 1'b0;
         socket_accessed_flag_r <= 1'b0;
         rdata_r <= socket_power_pkg::ZERO_WORD;
         card_supply_r <= socket_power_pkg::VCC_OFF;
         program_supply_r <= socket_power_pkg::VPP_OFF;
         clk_state_r <= socket_power_pkg::CLK_RUN;
      end else begin
         card_supply_request_r <= card_supply_request_nxt;
         program_supply_request_r <= program_supply_request_nxt;
         clock_halt_policy_r <= clock_halt_policy_nxt;
         clock_throttle_enable_r <= clock_throttle_enable_nxt;
         clock_throttle_select_r <= clock_throttle_select_nxt;
         socket_accessed_flag_r <= socket_accessed_flag_nxt;
         rdata_r <= rdata_nxt;
         card_supply_r <= card_supply_nxt;
         program_supply_r <= program_supply_nxt;
         clk_state_r <= clk_state_nxt;
      end
   end

   // Outputs from flip-flops; clock stop and slow are decoded from clk_state_r
   assign RDATA = rdata_r;
   assign CARD_SUPPLY = card_supply_r;
   assign PROGRAM_SUPPLY = program_supply_r;
   assign CARD_CLOCK_STOP = (clk_state_r == socket_power_pkg::CLK_STOP);
   assign CARD_CLOCK_SLOW = (clk_state_r == socket_power_pkg::CLK_SLOW);
endmodule : socket_power_regs
`default_nettype wire

// file: testbench/socket_power_assertions.sv
// Port checker for the socket power register bank
`timescale 1ns/1ps
`default_nettype none
module socket_power_assertions (
   // Clock, resets and register port
   input wire logic SYS_CLK, RESET, HOST_BUS_RESET, PM_EVENT_ENABLE, RD,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] RDATA,
   // Card status and power outputs
   input wire logic CARD_INSERTED, CARD_ACCEPTS_5V, CARD_ACCEPTS_3V3, CARD_ACCEPTS_ALT,
   input wire logic CARD_IDLE, CARD_ACCESS, CARD_CLOCK_STOP, CARD_CLOCK_SLOW,
   input wire logic [2:0] CARD_SUPPLY, PROGRAM_SUPPLY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // Read data is zero unless a read was taken
   AST_RDATA_IDLE: assert property (!RD |=> RDATA == 32'h0000_0000) else $error("rdata not idle");
   AST_VREQ_FIXED: assert property (
      RD && ADDR == 8'h10 |=> RDATA[31:8] == 24'h00_0004 && !RDATA[3]) else $error("vreq fixed");
   AST_IDLE_FIXED: assert property (
      RD && ADDR == 8'h20 |=> RDATA[31:26] == 6'h0 && RDATA[23:17] == 7'h0 && RDATA[15:1] == 15'h0)
      else $error("idle fixed");
   // Power only at a legal code the card accepts
   AST_VCC_OK: assert property (
      CARD_SUPPLY != 3'h0 |-> $past(CARD_INSERTED) && (CARD_SUPPLY == 3'h2 && $past(CARD_ACCEPTS_5V)
      || CARD_SUPPLY == 3'h3 && $past(CARD_ACCEPTS_3V3) || CARD_SUPPLY == 3'h5 && $past(CARD_ACCEPTS_ALT)))
      else $error("vcc applied badly");
   AST_VPP_OK: assert property (
      PROGRAM_SUPPLY != 3'h0 |-> CARD_SUPPLY != 3'h0 && PROGRAM_SUPPLY <= 3'h5) else $error("vpp bad");
   AST_CLK_EXCL: assert property (!(CARD_CLOCK_STOP && CARD_CLOCK_SLOW)) else $error("stop and slow");
   AST_CLK_IDLE: assert property (
      CARD_CLOCK_STOP || CARD_CLOCK_SLOW |-> $past(CARD_IDLE && !CARD_ACCESS)) else $error("clk busy");
   // Two cycles lets the cleared request reach the switch
   AST_HOST_RST: assert property (
      HOST_BUS_RESET && !PM_EVENT_ENABLE |-> ##2 CARD_SUPPLY == 3'h0 && PROGRAM_SUPPLY == 3'h0)
      else $error("supply kept");
endmodule : socket_power_assertions
bind socket_power_regs socket_power_assertions chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
   .HOST_BUS_RESET(HOST_BUS_RESET), .PM_EVENT_ENABLE(PM_EVENT_ENABLE), .RD(RD), .ADDR(ADDR),
   .RDATA(RDATA), .CARD_INSERTED(CARD_INSERTED), .CARD_ACCEPTS_5V(CARD_ACCEPTS_5V),
   .CARD_ACCEPTS_3V3(CARD_ACCEPTS_3V3), .CARD_ACCEPTS_ALT(CARD_ACCEPTS_ALT), .CARD_IDLE(CARD_IDLE),
   .CARD_ACCESS(CARD_ACCESS), .CARD_CLOCK_STOP(CARD_CLOCK_STOP), .CARD_CLOCK_SLOW(CARD_CLOCK_SLOW),
   .CARD_SUPPLY(CARD_SUPPLY), .PROGRAM_SUPPLY(PROGRAM_SUPPLY));
`default_nettype wire

// file: testbench/socket_card_model.sv
// Behavioural card and socket sense model
`timescale 1ns/1ps
`default_nettype none
module socket_card_model (
   // Bench controls
   input wire logic SYS_CLK, PLUG, BUSY,
   input wire logic [2:0] ACCEPTS,
   // Socket sense lines
   output logic CARD_INSERTED, CARD_ACCEPTS_5V, CARD_ACCEPTS_3V3, CARD_ACCEPTS_ALT,
   output logic CARD_IDLE, CARD_ACCESS
);
   // Sense lines lag the card by a clock; an empty socket senses no voltage
   always_ff @(posedge SYS_CLK) begin
      CARD_INSERTED <= PLUG;
      {CARD_ACCEPTS_ALT, CARD_ACCEPTS_3V3, CARD_ACCEPTS_5V} <= PLUG ? ACCEPTS : 3'h0;
      CARD_IDLE <= !BUSY;
      CARD_ACCESS <= BUSY;
   end
endmodule : socket_card_model
`default_nettype wire

// file: testbench/cardbus_socket_power_control_test.sv
// Self-checking bench for the socket power register bank
`timescale 1ns/1ps
`default_nettype none
module cardbus_socket_power_control_test;
   logic clk = 0, rst = 1, hbr = 0, pme = 1, wr = 0, rd = 0, plug = 0, busy = 0, crun = 0;
   logic [7:0] addr = 0;
   logic [31:0] wd = 0, rdata, got;
   logic [2:0] acc = 0, vcc, vpp, ev, csup, psup;
   logic ins, a5, a3, aa, idle, cacc, stp, slw;
   integer miscompares = 0, check_count = 0, seed = 32'h3d95, i;
   // 100 MHz clock
   always #5 clk = ~clk;
   socket_card_model card (.SYS_CLK(clk), .PLUG(plug), .BUSY(busy), .ACCEPTS(acc),
      .CARD_INSERTED(ins), .CARD_ACCEPTS_5V(a5), .CARD_ACCEPTS_3V3(a3), .CARD_ACCEPTS_ALT(aa),
      .CARD_IDLE(idle), .CARD_ACCESS(cacc));
   socket_power_regs dut (.SYS_CLK(clk), .RESET(rst), .HOST_BUS_RESET(hbr), .PM_EVENT_ENABLE(pme),
      .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .CARD_INSERTED(ins),
      .CARD_ACCEPTS_5V(a5), .CARD_ACCEPTS_3V3(a3), .CARD_ACCEPTS_ALT(aa), .CARD_IDLE(idle),
      .CARD_ACCESS(cacc), .HOST_CLKRUN_STOPPING(crun), .CARD_SUPPLY(csup),
      .PROGRAM_SUPPLY(psup), .CARD_CLOCK_STOP(stp), .CARD_CLOCK_SLOW(slw));
   // Bus cycles, strobes one cycle long
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, addr, wd} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask : rd_reg
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Supply the switch should apply for a request and the card's sense lines
   function automatic logic [2:0] exp_vcc(input logic [2:0] c, input logic [2:0] a);
      if ((c == 3'h2 && a[0]) || (c == 3'h3 && a[1]) || (c == 3'h5 && a[2])) return c;
      return 3'h0;
   endfunction : exp_vcc
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // Reset values, masks, supply codes, resets, clock policy, access flag
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h10); chk(got, 32'h0000_0400);
      rd_reg(8'h20); chk(got, 32'h0000_0000);
      wr_reg(8'h20, 32'hFFFF_FFFF); rd_reg(8'h20); chk(got, 32'h0001_0001);
      wr_reg(8'h10, 32'hFFFF_FFFF); rd_reg(8'h10); chk(got, 32'h0000_04F7);
      wr_reg(8'h30, 32'hFFFF_FFFF); rd_reg(8'h30); chk(got, 32'h0000_0000);
      plug <= 1'b1;
      for (i = 0; i < 24; i++) begin
         vcc = i[2:0];
         vpp = 3'($random(seed));
         acc <= (i < 8) ? 3'h7 : 3'($random(seed));
         wr_reg(8'h10, {25'h0, vcc, 1'b0, vpp});
         settle;
         ev = exp_vcc(vcc, acc);
         chk({29'h0, csup}, {29'h0, ev});
         chk({29'h0, psup}, (ev == 3'h0 || vpp > 3'h5) ? 32'h0 : {29'h0, vpp});
         rd_reg(8'h10); chk(got, {21'h0, 1'b1, 3'h0, vcc, 1'b0, vpp});
      end
      acc <= 3'h7;
      wr_reg(8'h10, 32'h0000_0020); settle; chk({29'h0, csup}, 32'h2);
      plug <= 1'b0; settle; chk({29'h0, csup}, 32'h0);
      plug <= 1'b1; acc <= 3'h7;
      wr_reg(8'h10, 32'h0000_0021);
      hbr <= 1'b1; @(posedge clk); hbr <= 1'b0; settle; chk({29'h0, csup}, 32'h2);
      pme <= 1'b0; hbr <= 1'b1; @(posedge clk); hbr <= 1'b0; settle;
      rd_reg(8'h10); chk(got, 32'h0000_0400);
      chk({26'h0, csup, psup}, 32'h0);
      for (i = 0; i < 8; i++) begin
         crun <= i[0];
         wr_reg(8'h10, {24'h0, i[2], 7'h0});
         wr_reg(8'h20, {15'h0, 1'b1, 15'h0, i[1]});
         settle;
         chk({30'h0, slw, stp}, (i[2] | i[0]) ? (i[1] ? 32'h2 : 32'h1) : 32'h0);
      end
      wr_reg(8'h20, 32'h1); settle; chk({30'h0, slw, stp}, 32'h0);
      busy <= 1'b1; @(posedge clk); busy <= 1'b0; settle;
      rd_reg(8'h20); chk(got & 32'h0200_0000, 32'h0200_0000);
      rd_reg(8'h20); chk(got & 32'h0200_0000, 32'h0);
      end_sim;
   end
endmodule : cardbus_socket_power_control_test
`default_nettype wire
